/* File: hdl/rbsd_map.vh */
// constants for the receive back end and sync detector
`ifndef RBSD_MAP_VH
`define RBSD_MAP_VH
`define RBSD_LEN_12        2'h0
`define RBSD_LEN_16        2'h1
`define RBSD_LEN_20        2'h2
`define RBSD_LEN_24        2'h3
`define RBSD_BITS_12       5'h0C
`define RBSD_BITS_16       5'h10
`define RBSD_BITS_20       5'h14
`define RBSD_BITS_24       5'h18
`define RBSD_PIN_OFF       2'h0
`define RBSD_PIN_PULSE     2'h1
`define RBSD_PIN_LEVEL     2'h2
`define RBSD_PIN_FRAME     2'h3
`define RBSD_SYM_ZERO      2'h0
`define RBSD_SYM_POS       2'h1
`define RBSD_SYM_NEG       2'h3
`define RBSD_BYTE_BITS     3'h7
`endif

/* File: hdl/rbsd_sync_match.v */
// sync word comparator with length select and error tolerance
`include "rbsd_map.vh"
module rbsd_sync_match (
    input  wire [23:0] shift_reg,
    input  wire [23:0] sync_word,
    input  wire [1:0]  sync_length,
    input  wire [1:0]  sync_tolerance,
    output reg         match
);
    reg [23:0] mask;
    reg [23:0] diff;
    reg [4:0]  errors;
    integer    i;
    always @* begin
        mask   = 24'h000000;
        errors = 5'h00;
        case (sync_length)
            `RBSD_LEN_12: mask = 24'h000FFF;
            `RBSD_LEN_16: mask = 24'h00FFFF;
            `RBSD_LEN_20: mask = 24'h0FFFFF;
            default:      mask = 24'hFFFFFF;
        endcase
        diff = (shift_reg ^ sync_word) & mask;
        for (i = 0; i < 24; i = i + 1) begin
            errors = errors + {4'h0, diff[i]};
        end
        match = (errors <= {3'h0, sync_tolerance});
    end
endmodule

/* File: hdl/rbsd_top.v */
// receive back end: slicer, frequency control and sync word detection
`include "rbsd_map.vh"
module rbsd_top #(
    parameter SAMPLE_W = 8
) (
    input  wire                clk,
    input  wire                reset,
    input  wire                rx_mode,
    input  wire                rx_clk_pin,
    input  wire                rx_data_pin,
    input  wire [SAMPLE_W-1:0] symbol_sample,
    input  wire                trellis_enable,
    input  wire [6:0]          multilevel_slicer_level,
    input  wire                phase_fix_enable,
    input  wire [6:0]          ternary_recovery_threshold,
    input  wire [3:0]          ternary_preamble_qualify_time,
    input  wire                freq_loop_enable,
    input  wire [11:0]         freq_loop_scale,
    input  wire [7:0]          freq_max_range,
    input  wire                rf_half_divider,
    input  wire [15:0]         freq_error,
    input  wire                freq_error_valid,
    input  wire [23:0]         sync_word,
    input  wire [1:0]          sync_length,
    input  wire [1:0]          sync_tolerance,
    input  wire [1:0]          sync_pin_mode,
    input  wire [7:0]          packet_length,
    input  wire                readback_load,
    input  wire                readback_shift,
    output reg  [1:0]          ternary_symbol,
    output reg  [15:0]         freq_correction,
    output reg                 readback_data,
    output reg                 sync_match
);
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    reg [2:0] clk_sync;
    reg [2:0] data_sync;
    reg       clk_state;
    reg       data_state;
    always @(posedge clk) begin
        if (reset) begin
            clk_sync   <= 3'h0;
            data_sync  <= 3'h0;
            clk_state  <= 1'b0;
            data_state <= 1'b0;
        end else begin
            clk_sync  <= {clk_sync[1:0], rx_clk_pin};
            data_sync <= {data_sync[1:0], rx_data_pin};
            if (clk_sync[2] == clk_sync[1])
                clk_state <= clk_sync[1];
            if (data_sync[2] == data_sync[1])
                data_state <= data_sync[1];
        end
    end
    wire rx_clk_rise = (clk_sync[2] == clk_sync[1]) && clk_sync[1] && !clk_state;

    // ---------------------------------------------------------------
    // 3-level slicer
    // ---------------------------------------------------------------
    wire signed [SAMPLE_W:0] samp = {symbol_sample[SAMPLE_W-1], symbol_sample};
    wire signed [SAMPLE_W:0] thr  = $signed({{(SAMPLE_W-6){1'b0}}, multilevel_slicer_level});
    wire signed [SAMPLE_W:0] cdr  = $signed({{(SAMPLE_W-6){1'b0}}, ternary_recovery_threshold});
    reg  [1:0] prev_sym;
    reg  [3:0] qual_cnt;
    reg  [1:0] next_sym;
    always @* begin
        next_sym = `RBSD_SYM_ZERO;
        if (!trellis_enable) begin
            if (samp > thr)
                next_sym = `RBSD_SYM_POS;
            else if (samp < -thr)
                next_sym = `RBSD_SYM_NEG;
        end else begin
            // two-state path choice: recovery level to enter, slicer level to hold the last symbol
            if (samp > cdr || (prev_sym == `RBSD_SYM_POS && samp > thr))
                next_sym = `RBSD_SYM_POS;
            else if (samp < -cdr || (prev_sym == `RBSD_SYM_NEG && samp < -thr))
                next_sym = `RBSD_SYM_NEG;
        end
    end
    always @(posedge clk) begin
        if (reset) begin
            ternary_symbol <= `RBSD_SYM_ZERO;
            prev_sym       <= `RBSD_SYM_ZERO;
            qual_cnt       <= 4'h0;
        end else if (rx_clk_rise) begin
            prev_sym <= phase_fix_enable ? next_sym : ternary_symbol;
            if (next_sym != prev_sym)
                qual_cnt <= 4'h0;
            else if (qual_cnt != ternary_preamble_qualify_time)
                qual_cnt <= qual_cnt + 4'h1;
            ternary_symbol <= next_sym;
        end
    end

    // ---------------------------------------------------------------
    // frequency control loop
    // ---------------------------------------------------------------
    reg  signed [23:0] integ;
    wire signed [8:0]  span = rf_half_divider ? {2'b00, freq_max_range[7:1]}
                                              : {1'b0, freq_max_range};
    wire signed [15:0] lim  = {{8{1'b0}}, span[8:1]};
    wire signed [27:0] prod = $signed(freq_error) * $signed({1'b0, freq_loop_scale[11:1]});
    wire signed [23:0] next_integ = integ + {{8{freq_error[15]}}, freq_error};
    wire signed [23:0] pi_sum = next_integ + {{12{prod[27]}}, prod[27:16]};
    wire signed [15:0] pi_out = pi_sum[23:8];
    reg  [15:0] readback;
    always @(posedge clk) begin
        if (reset) begin
            integ           <= 24'h000000;
            freq_correction <= 16'h0000;
            readback        <= 16'h0000;
            readback_data   <= 1'b0;
        end else begin
            if (freq_error_valid && freq_loop_enable) begin
                integ <= next_integ;
                if (pi_out > lim)
                    freq_correction <= lim;
                else if (pi_out < -lim)
                    freq_correction <= -lim;
                else
                    freq_correction <= pi_out;
            end else if (!freq_loop_enable) begin
                integ           <= 24'h000000;
                freq_correction <= 16'h0000;
            end
            if (readback_load) begin
                readback      <= freq_error;
                readback_data <= freq_error[15];
            end else if (readback_shift) begin
                readback      <= {readback[14:0], 1'b0};
                readback_data <= readback[14];
            end
        end
    end

    // ---------------------------------------------------------------
    // sync word detection and framing
    // ---------------------------------------------------------------
    reg  [23:0] shift_reg;
    reg         found;
    reg  [7:0]  byte_cnt;
    reg  [2:0]  bit_cnt;
    reg         framing;
    wire        match;
    rbsd_sync_match u_match (
        .shift_reg      (shift_reg),
        .sync_word      (sync_word),
        .sync_length    (sync_length),
        .sync_tolerance (sync_tolerance),
        .match          (match)
    );
    always @(posedge clk) begin
        if (reset) begin
            shift_reg  <= 24'h000000;
            found      <= 1'b0;
            byte_cnt   <= 8'h00;
            bit_cnt    <= 3'h0;
            framing    <= 1'b0;
            sync_match <= 1'b0;
        end else if (!rx_mode) begin
            found      <= 1'b0;
            framing    <= 1'b0;
            sync_match <= 1'b0;
        end else if (rx_clk_rise) begin
            shift_reg <= {shift_reg[22:0], data_state};
            found     <= match && !framing;
            case (sync_pin_mode)
                `RBSD_PIN_OFF:   sync_match <= 1'b0;
                `RBSD_PIN_PULSE: sync_match <= found;
                `RBSD_PIN_LEVEL: sync_match <= found | sync_match;
                default: begin
                    if (found && !framing) begin
                        framing    <= (packet_length != 8'h00);
                        sync_match <= (packet_length != 8'h00);
                        byte_cnt   <= 8'h00;
                        bit_cnt    <= 3'h0;
                    end else if (framing) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == `RBSD_BYTE_BITS) begin
                            byte_cnt <= byte_cnt + 8'h01;
                            if (byte_cnt + 8'h01 == packet_length) begin
                                framing    <= 1'b0;
                                sync_match <= 1'b0;
                            end
                        end
                    end
                end
            endcase
        end
    end
endmodule

/* File: verif/rbsd_checker.sv */
// port assertions for the receive back end
`include "rbsd_map.vh"
module rbsd_checker (
    input logic        clk,
    input logic        reset,
    input logic        rx_mode,
    input logic        rx_clk_pin,
    input logic [1:0]  sync_pin_mode,
    input logic        freq_loop_enable,
    input logic [7:0]  freq_max_range,
    input logic        rf_half_divider,
    input logic [15:0] freq_error,
    input logic        freq_error_valid,
    input logic        readback_load,
    input logic        readback_shift,
    input logic [1:0]  ternary_symbol,
    input logic [15:0] freq_correction,
    input logic        readback_data,
    input logic        sync_match
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge clk); endclocking
default disable iff (reset);
logic [7:0] lim_d;
// correction limit in force at the previous edge
always_ff @(posedge clk) lim_d <= rf_half_divider ? freq_max_range >> 2 : freq_max_range >> 1;
sequence s_load_shift;
    readback_load ##1 (readback_shift && !readback_load);
endsequence
chk_rx_off_clear: assert property (!rx_mode |=> !sync_match)
    else $error("sync pin high outside receive");
chk_pin_off_quiet: assert property ($past(sync_pin_mode) == `RBSD_PIN_OFF &&
    sync_pin_mode == `RBSD_PIN_OFF |-> !sync_match) else $error("sync pin high in off mode");
chk_match_rx_edge: assert property ($rose(sync_match) |-> $past(rx_clk_pin, 2))
    else $error("sync pin rose away from a receive clock");
chk_loop_off_zero: assert property (!freq_loop_enable ##1 !freq_loop_enable |->
    freq_correction == 16'h0000) else $error("correction with loop disabled");
chk_range_clamp: assert property (freq_error_valid && freq_loop_enable |=>
    $signed(freq_correction) <= $signed({8'h00, lim_d}) &&
    $signed(freq_correction) >= -$signed({8'h00, lim_d})) else $error("correction out of range");
chk_load_msb: assert property (readback_load |=> readback_data == $past(freq_error[15]))
    else $error("readback msb wrong");
chk_shift_next: assert property (s_load_shift |=> readback_data == $past(freq_error[14], 2))
    else $error("readback second bit wrong");
chk_symbol_code: assert property (ternary_symbol != 2'h2)
    else $error("illegal symbol code");
endmodule

/* File: verif/rbsd_host.sv */
// host side model: receive clock and recovered bits
module rbsd_host (
    input  logic clk,
    output logic rx_clk_pin,
    output logic rx_data_pin
);
timeunit 1ns;
timeprecision 1ns;
initial rx_clk_pin = 1'b0;
initial rx_data_pin = 1'b0;
// clock stands low between bits, data goes stale after its hold
task automatic send_bit(input logic b);
    @(posedge clk) rx_data_pin <= b;
    repeat (4) @(posedge clk);
    rx_clk_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rx_clk_pin <= 1'b0;
    repeat (3) @(posedge clk);
    rx_data_pin <= ~b;
endtask
task automatic send_word(input logic [23:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) send_bit(w[i]);
endtask
endmodule

/* File: verif/rbsd_top_tb.sv */
// self-checking bench for the receive back end
`include "rbsd_map.vh"
`define RBSD_CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module rbsd_top_tb;
timeunit 1ns;
timeprecision 1ns;
localparam logic [23:0] SW = 24'hB38E5C;
logic        clk = 1'b0, reset = 1'b1, rx_mode = 1'b0, rx_clk_pin, rx_data_pin, rx_q = 1'b0;
logic        trellis_enable = 1'b0, freq_loop_enable = 1'b0, rf_half_divider = 1'b0;
logic        freq_error_valid = 1'b0, readback_load = 1'b0, readback_shift = 1'b0;
logic        phase_fix_enable = 1'b1;
logic [3:0]  ternary_preamble_qualify_time = 4'hF;
logic [6:0]  ternary_recovery_threshold = 7'h1F;
logic [11:0] freq_loop_scale = 12'h347;
logic [6:0]  multilevel_slicer_level = 7'h14;
logic [7:0]  symbol_sample = 8'h00, freq_max_range = 8'h10, packet_length = 8'h01;
logic [15:0] freq_error = 16'h0000, freq_correction;
logic [23:0] sync_word = SW;
logic [1:0]  sync_length = 2'h3, sync_tolerance = 2'h0, sync_pin_mode = 2'h0, ternary_symbol;
logic        readback_data, sync_match;
int          failures = 0, tests_run = 0, cycles = 0, hi = 0, hb = 0;
rbsd_top i_dut (.*);
rbsd_host i_host (.*);
always #50 clk = ~clk;
// high clocks and high receive bits of the sync pin, plus the run limit
always @(posedge clk) begin
    rx_q <= rx_clk_pin;
    hi <= sync_match ? hi + 1 : hi;
    hb <= (sync_match && rx_clk_pin && !rx_q) ? hb + 1 : hb;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        failures++;
        results();
    end
end
task automatic fresh(input logic [1:0] len, tol, mode);
    @(posedge clk) rx_mode <= 1'b0;
    sync_length <= len;
    sync_tolerance <= tol;
    sync_pin_mode <= mode;
    @(posedge clk) rx_mode <= 1'b1;
endtask
task automatic match_case(input logic [1:0] len, tol, mode, input logic [23:0] w,
                          input int n, input logic exp);
    int h0;
    fresh(len, tol, mode);
    h0 = hi;
    i_host.send_word(w, n);
    i_host.send_word(24'h2, 3);
    `RBSD_CHK(hi != h0, exp)
    `RBSD_CHK(sync_match, 1'b0)
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_sync;
    for (int c = 0; c < 4; c++) match_case(c, 0, `RBSD_PIN_PULSE, SW, 12 + 4 * c, 1);
    match_case(`RBSD_LEN_24, 0, `RBSD_PIN_PULSE, SW, 12, 0);
    match_case(`RBSD_LEN_24, 0, `RBSD_PIN_OFF, SW, 24, 0);
    for (int t = 0; t < 4; t++) begin
        match_case(3, t, `RBSD_PIN_PULSE, SW ^ ((24'h1 << t) - 1), 24, 1);
        match_case(3, t, `RBSD_PIN_PULSE, SW ^ ((24'h1 << (t + 1)) - 1), 24, 0);
    end
endtask
task automatic t_frame(input logic [7:0] len, input int exp);
    int b0;
    packet_length <= len;
    fresh(`RBSD_LEN_24, 0, `RBSD_PIN_FRAME);
    b0 = hb;
    repeat (40) i_host.send_bit(1'b1);
    i_host.send_word(SW, 24);
    i_host.send_word(24'h0F0, 12);
    `RBSD_CHK(hb - b0, exp)
endtask
task automatic t_level;
    fresh(`RBSD_LEN_24, 0, `RBSD_PIN_LEVEL);
    i_host.send_word(24'h222222, 24);
    i_host.send_word(24'h22, 8);
    i_host.send_word(SW, 24);
    i_host.send_word(24'h35A, 10);
    `RBSD_CHK(sync_match, 1'b1)
    @(posedge clk) rx_mode <= 1'b0;
    repeat (2) @(posedge clk);
    `RBSD_CHK(sync_match, 1'b0)
endtask
task automatic slice(input logic tr, input logic [7:0] s, input logic [1:0] e);
    @(posedge clk) trellis_enable <= tr;
    symbol_sample <= s;
    i_host.send_bit(1'b0);
    `RBSD_CHK(ternary_symbol, e)
endtask
task automatic freq_case(input logic half, input logic [15:0] err, lim);
    @(posedge clk) freq_loop_enable <= 1'b0;
    rf_half_divider <= half;
    freq_error <= err;
    @(posedge clk) freq_loop_enable <= 1'b1;
    repeat (40) begin
        @(posedge clk) freq_error_valid <= 1'b1;
        @(posedge clk) freq_error_valid <= 1'b0;
    end
    @(negedge clk);
    `RBSD_CHK(freq_correction, lim)
endtask
task automatic t_readback(input logic [15:0] d);
    @(posedge clk) freq_error <= d;
    readback_load <= 1'b1;
    @(posedge clk) readback_load <= 1'b0;
    readback_shift <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
        @(negedge clk);
        `RBSD_CHK(readback_data, d[i])
        @(posedge clk) readback_shift <= (i > 1);
    end
endtask
task results;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
endtask
initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_sync();
    t_frame(8'h01, 8);
    t_frame(8'h00, 0);
    t_level();
    slice(0, 8'h28, `RBSD_SYM_POS);
    slice(0, 8'hD8, `RBSD_SYM_NEG);
    slice(0, 8'h05, `RBSD_SYM_ZERO);
    slice(1, 8'h60, `RBSD_SYM_POS);
    slice(1, 8'hA0, `RBSD_SYM_NEG);
    slice(1, 8'h19, `RBSD_SYM_ZERO);
    freq_case(0, 16'h7FFF, 16'h0008);
    freq_case(1, 16'h7FFF, 16'h0004);
    freq_case(0, 16'h8001, 16'hFFF8);
    @(posedge clk) freq_loop_enable <= 1'b0;
    repeat (2) @(posedge clk);
    `RBSD_CHK(freq_correction, 16'h0000)
    t_readback(16'hA5C3);
    results();
end
endmodule
bind rbsd_top rbsd_checker i_chk (.*);
